// *** logic/hp_slot_pkg.sv ***
/*
 * hp_slot_pkg: offsets, field positions, reset values and carrier structs
 * for the hot-plug slot capability / slot control register block.
 * assumes a word-wide register port; offsets are byte addresses.
 */
package hp_slot_pkg;

    // register offsets
    localparam logic [11:0] OFF_SLOT_CAP    = 12'h054;
    localparam logic [11:0] OFF_SLOT_CTL    = 12'h058;
    localparam logic [11:0] OFF_SLOT_STS    = 12'h05A;
    localparam logic [11:0] OFF_PORT_CFG    = 12'h100;

    // slot capability field positions
    localparam int CAP_ABP_BIT     = 0;
    localparam int CAP_PCP_BIT     = 1;
    localparam int CAP_MRLP_BIT    = 2;
    localparam int CAP_ATT_IND_BIT = 3;
    localparam int CAP_PWR_IND_BIT = 4;
    localparam int CAP_HOT_BIT     = 6;
    localparam int CAP_PLV_LSB     = 7;
    localparam int CAP_PLS_LSB     = 15;
    localparam int CAP_ILK_BIT     = 17;
    localparam int CAP_NOCMD_BIT   = 18;
    localparam int CAP_PSN_LSB     = 19;

    // slot control field positions
    localparam int CTL_ATT_LSB   = 6;
    localparam int CTL_PWR_LSB   = 8;
    localparam int CTL_POFF_BIT  = 10;

    // port config register: bit 0 slot implemented, bit 1 upstream port
    localparam int CFG_SLOT_BIT  = 0;
    localparam int CFG_UP_BIT    = 1;

    // reset values
    localparam logic [1:0] ATT_RESET = 2'h3;
    localparam logic [1:0] PWR_RESET = 2'h1;
    localparam logic       POFF_RESET = 1'h0;

    // indicator encodings
    localparam logic [1:0] IND_ON    = 2'h1;
    localparam logic [1:0] IND_BLINK = 2'h2;
    localparam logic [1:0] IND_OFF   = 2'h3;

    // number of slot event kinds: button, fault, latch, presence, cmd done
    localparam int NUM_EVT = 5;

    typedef struct packed {
        logic        hot_plug_capable;
        logic [7:0]  power_limit_value;
        logic [1:0]  power_limit_scale;
        logic        interlock_present;
        logic [12:0] physical_slot_number;
        logic [4:0]  lower_present;       // button, power ctl, latch, att ind, pwr ind
    } slot_cap_s;

    typedef struct packed {
        logic [NUM_EVT-1:0] evt_enable;  // button, fault, latch, presence, cmd done
        logic               hot_plug_irq_enable;
        logic [1:0]         attention_indicator_ctrl;
        logic [1:0]         power_indicator_ctrl;
        logic               power_controller_ctrl;
    } slot_ctl_s;

    // outputs toward the slot hardware
    typedef struct packed {
        logic [1:0] attention_ind;
        logic [1:0] power_ind;
        logic       power_off;
        logic       hot_plug_irq;
        logic       wake;
        logic       send_power_limit;
        logic [9:0] power_limit_msg;     // {scale, value}
    } slot_out_s;

endpackage : hp_slot_pkg

// *** logic/hp_slot_regs.sv ***
/*
 * hp_slot_regs: hot-plug slot capability, slot control and slot status
 * registers for one switch port, with event latching, interrupt gating
 * and power-limit message trigger.
 * assumes a single-cycle register port (read data the cycle after the
 * read strobe) and asynchronous slot event / link inputs from pins.
 */
// Function
// RULE1: hot-plug-capable bit reports hot-plug support, loadable, resets zero.
// RULE2: eight-bit power limit value defines slot maximum power with scale.
// RULE3: two-bit scale decodes 0..3 as 1.0, 0.1, 0.01, 0.001.
// RULE4: send power-limit message on capability write and on entering link up.
// RULE5: slot not implemented makes all capability fields read-only zero.
// RULE6: loadable interlock-present bit at position 17.
// RULE7: no-command-completed-support bit hardwired to zero.
// RULE8: software should load slot number zero for system board devices.
// RULE9: control bit 0 enables event on attention button press.
// RULE10: control bit 1 enables event on power fault.
// RULE11: control bit 2 enables event on latch sensor change.
// RULE12: control bit 3 enables presence change event, always writable.
// RULE13: control bit 4 enables interrupt on command completion.
// RULE14: control bit 5 gates every hot-plug interrupt.
// RULE15: control fields without enabled capability are read-only zero.
// RULE16: attention indicator field drives indicator, reads state, resets to 3.
// RULE17: attention field reads zero while its present bit is clear.
// RULE18: power indicator field drives indicator, resets 1, zero if absent.
// RULE19: upstream port power indicator writes never reach indicator output.
// RULE20: power controller bit sets slot power, 1 off, resets 0.
// RULE21: sticky write-one-to-clear status flag for each slot event.
// RULE22: interrupt while enabled flag set and master enable set.
`timescale 1ns/10ps
`default_nettype none

module hp_slot_regs #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rstn_i,
    // register port
    input  wire logic [ADDR_W-1:0]              addr_i,
    input  wire logic [31:0]                    wdata_i,
    input  wire logic                           wr_i,
    input  wire logic                           rd_i,
    output logic      [31:0]                    rdata_o,
    // slot hardware events and link state (asynchronous)
    input  wire logic                           button_press_i,
    input  wire logic                           power_fault_i,
    input  wire logic                           latch_open_i,
    input  wire logic                           presence_i,
    input  wire logic                           cmd_done_i,
    input  wire logic                           dl_up_i,
    // slot hardware controls and messages
    output hp_slot_pkg::slot_out_s              slot_o
);

    typedef struct packed {
        hp_slot_pkg::slot_cap_s                 cap;
        hp_slot_pkg::slot_ctl_s                 ctl;
        logic [hp_slot_pkg::NUM_EVT-1:0]        sts;
        logic                                   slot_impl;
        logic                                   upstream;
        logic [hp_slot_pkg::NUM_EVT:0]          sync1;  // events + dl_up
        logic [hp_slot_pkg::NUM_EVT:0]          sync2;
        logic [hp_slot_pkg::NUM_EVT:0]          prev;
        logic [31:0]                            rdata;
        hp_slot_pkg::slot_out_s                 out;
    } state_s;

    state_s state;
    state_s next_state;

    // capability and control views as software sees them
    logic [31:0] cap_view;
    logic [15:0] ctl_view;
    logic [4:0]  ctl_allowed;
    logic [hp_slot_pkg::NUM_EVT:0] raw_in;
    logic [hp_slot_pkg::NUM_EVT-1:0] evt_pulse;
    logic        dl_up_rise;

    assign raw_in = {dl_up_i, cmd_done_i, presence_i, latch_open_i, power_fault_i,
                     button_press_i};

    // per-event edge detection; presence and latch fire on any change
    genvar g;
    generate
        for (g = 0; g < hp_slot_pkg::NUM_EVT; g++) begin : g_evt
            if (g == 2 || g == 3) begin : g_any
                assign evt_pulse[g] = state.sync2[g] ^ state.prev[g];
            end else begin : g_rise
                assign evt_pulse[g] = state.sync2[g] & ~state.prev[g];
            end
        end
    endgenerate

    assign dl_up_rise = state.sync2[hp_slot_pkg::NUM_EVT] & ~state.prev[hp_slot_pkg::NUM_EVT];

    // capability enables per control bit: button, fault, latch, presence, cmd
    always_comb begin
        ctl_allowed[0] = state.cap.lower_present[0] & state.slot_impl;
        ctl_allowed[1] = state.cap.lower_present[1] & state.slot_impl;
        ctl_allowed[2] = state.cap.lower_present[2] & state.slot_impl;
        ctl_allowed[3] = 1'b1;                                          // RULE12
        ctl_allowed[4] = state.cap.hot_plug_capable & state.slot_impl;
    end

    // read views; absent slot forces every capability field to zero
    always_comb begin
        cap_view = 32'h00000000;
        if (state.slot_impl) begin                                      // RULE5
            cap_view[4:0]                           = state.cap.lower_present;
            cap_view[hp_slot_pkg::CAP_HOT_BIT]      = state.cap.hot_plug_capable; // RULE1
            cap_view[hp_slot_pkg::CAP_PLV_LSB +: 8] = state.cap.power_limit_value; // RULE2
            cap_view[hp_slot_pkg::CAP_PLS_LSB +: 2] = state.cap.power_limit_scale; // RULE3
            cap_view[hp_slot_pkg::CAP_ILK_BIT]      = state.cap.interlock_present; // RULE6
            cap_view[hp_slot_pkg::CAP_PSN_LSB +: 13] = state.cap.physical_slot_number;
        end
        cap_view[hp_slot_pkg::CAP_NOCMD_BIT] = 1'b0;                    // RULE7
        ctl_view = 16'h0000;
        ctl_view[4:0] = state.ctl.evt_enable & ctl_allowed;            // RULE15
        ctl_view[5]   = state.ctl.hot_plug_irq_enable & state.cap.hot_plug_capable
                        & state.slot_impl;
        if (state.cap.lower_present[3] && state.slot_impl) begin       // RULE17
            ctl_view[hp_slot_pkg::CTL_ATT_LSB +: 2] = state.ctl.attention_indicator_ctrl;
        end
        if (state.cap.lower_present[4] && state.slot_impl) begin       // RULE18
            ctl_view[hp_slot_pkg::CTL_PWR_LSB +: 2] = state.ctl.power_indicator_ctrl;
        end
        if (state.cap.lower_present[1] && state.slot_impl) begin
            ctl_view[hp_slot_pkg::CTL_POFF_BIT] = state.ctl.power_controller_ctrl;
        end
    end

    // next-state logic for registers, synchronisers and outputs
    always_comb begin
        next_state = state;
        next_state.sync1 = raw_in;
        next_state.sync2 = state.sync1;
        next_state.prev  = state.sync2;
        next_state.out.send_power_limit = 1'b0;

        // sticky event flags; a new event wins over a same-cycle clear
        if (wr_i && addr_i == ADDR_W'(hp_slot_pkg::OFF_SLOT_STS)) begin
            next_state.sts = state.sts & ~wdata_i[hp_slot_pkg::NUM_EVT-1:0]; // RULE21
        end
        next_state.sts = next_state.sts | evt_pulse;                    // RULE21

        if (wr_i) begin
            case (addr_i)
                ADDR_W'(hp_slot_pkg::OFF_PORT_CFG): begin
                    next_state.slot_impl = wdata_i[hp_slot_pkg::CFG_SLOT_BIT];
                    next_state.upstream  = wdata_i[hp_slot_pkg::CFG_UP_BIT];
                end
                ADDR_W'(hp_slot_pkg::OFF_SLOT_CAP): begin
                    if (state.slot_impl) begin                          // RULE5
                        next_state.cap.lower_present     = wdata_i[4:0];
                        next_state.cap.hot_plug_capable  =
                            wdata_i[hp_slot_pkg::CAP_HOT_BIT];         // RULE1
                        next_state.cap.power_limit_value =
                            wdata_i[hp_slot_pkg::CAP_PLV_LSB +: 8];    // RULE2
                        next_state.cap.power_limit_scale =
                            wdata_i[hp_slot_pkg::CAP_PLS_LSB +: 2];    // RULE3
                        next_state.cap.interlock_present =
                            wdata_i[hp_slot_pkg::CAP_ILK_BIT];         // RULE6
                        next_state.cap.physical_slot_number =
                            wdata_i[hp_slot_pkg::CAP_PSN_LSB +: 13];   // RULE8
                        next_state.out.send_power_limit = 1'b1;        // RULE4
                    end
                end
                ADDR_W'(hp_slot_pkg::OFF_SLOT_CTL): begin
                    for (int i = 0; i < hp_slot_pkg::NUM_EVT; i++) begin
                        if (ctl_allowed[i]) begin                       // RULE15
                            next_state.ctl.evt_enable[i] = wdata_i[i]; // RULE9 RULE10 RULE11 RULE12 RULE13
                        end
                    end
                    if (state.cap.hot_plug_capable && state.slot_impl) begin
                        next_state.ctl.hot_plug_irq_enable = wdata_i[5]; // RULE14
                    end
                    if (state.cap.lower_present[3] && state.slot_impl) begin
                        next_state.ctl.attention_indicator_ctrl =
                            wdata_i[hp_slot_pkg::CTL_ATT_LSB +: 2];    // RULE16
                    end
                    if (state.cap.lower_present[4] && state.slot_impl) begin
                        next_state.ctl.power_indicator_ctrl =
                            wdata_i[hp_slot_pkg::CTL_PWR_LSB +: 2];    // RULE18
                    end
                    if (state.cap.lower_present[1] && state.slot_impl) begin
                        next_state.ctl.power_controller_ctrl =
                            wdata_i[hp_slot_pkg::CTL_POFF_BIT];        // RULE20
                    end
                end
                default: begin
                end
            endcase
        end

        // link entering the up state also re-sends the power limit
        if (dl_up_rise && state.slot_impl) begin
            next_state.out.send_power_limit = 1'b1;                    // RULE4
        end
        next_state.out.power_limit_msg = {next_state.cap.power_limit_scale,
                                          next_state.cap.power_limit_value}; // RULE4

        // read data: one cycle after the strobe, zero otherwise
        next_state.rdata = 32'h00000000;
        if (rd_i) begin
            case (addr_i)
                ADDR_W'(hp_slot_pkg::OFF_SLOT_CAP): next_state.rdata = cap_view;
                ADDR_W'(hp_slot_pkg::OFF_SLOT_CTL): next_state.rdata = {16'h0000, ctl_view};
                ADDR_W'(hp_slot_pkg::OFF_SLOT_STS):
                    next_state.rdata = {27'h0000000, state.sts};
                ADDR_W'(hp_slot_pkg::OFF_PORT_CFG):
                    next_state.rdata = {30'h00000000, state.upstream, state.slot_impl};
                default: next_state.rdata = 32'h00000000;
            endcase
        end

        // indicator and power drives follow the visible control values; the power indicator drive holds on an upstream port
        next_state.out.attention_ind = ctl_view[hp_slot_pkg::CTL_ATT_LSB +: 2]; // RULE16
        if (!state.upstream) begin                                      // RULE19
            next_state.out.power_ind = ctl_view[hp_slot_pkg::CTL_PWR_LSB +: 2];
        end
        next_state.out.power_off = ctl_view[hp_slot_pkg::CTL_POFF_BIT]; // RULE20

        // interrupt: level from flags, masked per event and by master enable
        next_state.out.hot_plug_irq = |(state.sts & ctl_view[4:0]) & ctl_view[5]; // RULE22 RULE14
        // wake-up ignores the command-done event and the master gate
        next_state.out.wake = |(state.sts[3:0] & ctl_view[3:0]);      // RULE9 RULE10 RULE11
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= '0;
            state.ctl.attention_indicator_ctrl <= hp_slot_pkg::ATT_RESET;
            state.ctl.power_indicator_ctrl     <= hp_slot_pkg::PWR_RESET;
            state.ctl.power_controller_ctrl    <= hp_slot_pkg::POFF_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign rdata_o = state.rdata;
    assign slot_o  = state.out;

endmodule : hp_slot_regs

`default_nettype wire

// *** tb/hp_slot_checker.sv ***
/* hp_slot_checker: port assertions for hp_slot_regs.
   assumes port config and slot control change only through the register port. */
`timescale 1ns/10ps
`default_nettype none
module hp_slot_checker #(parameter int ADDR_W = 12) (
    // clock, reset and register port
    input wire logic              clk_i,
    input wire logic              rstn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0]       wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [31:0]       rdata_o,
    // link state and slot side
    input wire logic              dl_up_i,
    input wire hp_slot_pkg::slot_out_s slot_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic       rd_cap, rd_ctl, wr_cap, wr_ctl, master_en, dl_q;
    logic [1:0] cfg;
    logic [9:0] cap_val;
    logic [3:0] dl_cnt;
    assign rd_cap = rd_i && addr_i == hp_slot_pkg::OFF_SLOT_CAP;
    assign rd_ctl = rd_i && addr_i == hp_slot_pkg::OFF_SLOT_CTL;
    assign wr_cap = wr_i && addr_i == hp_slot_pkg::OFF_SLOT_CAP;
    assign wr_ctl = wr_i && addr_i == hp_slot_pkg::OFF_SLOT_CTL;
    // shadows of bus writes; the master enable shadow may be set while the design reads zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg     <= 2'h0;
            master_en <= 1'h0;
            dl_q    <= 1'h0;
            dl_cnt  <= 4'h0;
            cap_val <= 10'h000;
        end else begin
            if (wr_i && addr_i == hp_slot_pkg::OFF_PORT_CFG) cfg <= wdata_i[1:0];
            if (wr_ctl) master_en <= wdata_i[5];
            if (wr_cap) cap_val <= wdata_i[16:7];
            dl_q    <= dl_up_i;
            dl_cnt  <= (dl_up_i && !dl_q) ? 4'h8 : dl_cnt - {3'h0, dl_cnt != 4'h0};
        end
    end
    a_cmd_support_zero: assert property (rd_cap |=> !rdata_o[18])
        else $error("no-command-completed bit read as one");
    a_slot_off: assert property (rd_cap && !cfg[0] |=> rdata_o == 32'h0)
        else $error("capability nonzero without a slot");
    // the presence change enable stays writable even without a slot
    a_ctl_off: assert property (rd_ctl && !cfg[0] |=> (rdata_o & 32'hFFFF_FFF7) == 32'h0)
        else $error("control nonzero without capabilities");
    a_cap_msg: assert property (wr_cap && cfg[0] |-> ##[1:2]
        (slot_o.send_power_limit && slot_o.power_limit_msg == cap_val))
        else $error("no power limit message after capability write");
    a_link_msg: assert property ($rose(dl_up_i) && cfg[0] |->
        ##[1:6] slot_o.send_power_limit)
        else $error("no power limit message after link up");
    a_msg_cause: assert property (slot_o.send_power_limit |->
        $past(wr_cap) || $past(wr_cap, 2) || dl_cnt != 4'h0)
        else $error("power limit message without a cause");
    a_irq_master: assert property (slot_o.hot_plug_irq |-> master_en || $past(master_en))
        else $error("interrupt while master enable clear");
    a_pwr_hold: assert property (cfg[1] && wr_ctl |-> ##2
        slot_o.power_ind == $past(slot_o.power_ind, 2))
        else $error("power indicator moved on upstream port");
    c_irq: cover property (slot_o.hot_plug_irq);
    c_msg: cover property (slot_o.send_power_limit);
    c_up: cover property (cfg[1] && wr_ctl);
endmodule : hp_slot_checker
bind hp_slot_regs hp_slot_checker #(.ADDR_W(ADDR_W)) chk_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .dl_up_i(dl_up_i), .slot_o(slot_o)
);
`default_nettype wire

// *** tb/slot_hw.sv ***
/* slot_hw: model of the sensors and controller behind one slot.
   assumes one-cycle event requests from the bench. */
`timescale 1ns/10ps
`default_nettype none
module slot_hw (
    // clock and requests: button, fault, latch, presence, cmd done
    input wire logic       clk_i,
    input wire logic [4:0] evt_req_i,
    // sensor lines toward the port
    output logic           button_press_o,
    output logic           power_fault_o,
    output logic           latch_open_o,
    output logic           presence_o,
    output logic           cmd_done_o
);
    logic [3:0] btn = 4'h0, flt = 4'h0, cmd = 4'h0;
    logic       lat = 1'b0, pres = 1'b0;
    // pulsed sources hold four cycles so the port's synchroniser cannot miss them
    always_ff @(posedge clk_i) begin
        btn  <= {btn[2:0], evt_req_i[0]};
        flt  <= {flt[2:0], evt_req_i[1]};
        cmd  <= {cmd[2:0], evt_req_i[4]};
        lat  <= lat ^ evt_req_i[2];
        pres <= pres ^ evt_req_i[3];
    end
    assign button_press_o = |btn;
    assign power_fault_o  = |flt;
    assign cmd_done_o     = |cmd;
    assign latch_open_o   = lat;
    assign presence_o     = pres;
endmodule : slot_hw
`default_nettype wire

// *** tb/tb_hp_slot_regs.sv ***
/* tb_hp_slot_regs: directed bench for the slot register block.
   assumes slot_hw on the sensor side and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_hp_slot_regs;
    localparam logic [11:0] CAP = hp_slot_pkg::OFF_SLOT_CAP;
    localparam logic [11:0] CTL = hp_slot_pkg::OFF_SLOT_CTL;
    localparam logic [11:0] STS = hp_slot_pkg::OFF_SLOT_STS;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, dl_up = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [4:0]  evt_req = 5'h00;
    logic btn, flt, lat, pres, cmd;
    hp_slot_pkg::slot_out_s slot;
    int n_fail = 0, cmp_count = 0, cycles = 0;
    always #5 clk = ~clk;
    hp_slot_regs DUT (.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .button_press_i(btn), .power_fault_i(flt),
        .latch_open_i(lat), .presence_i(pres), .cmd_done_i(cmd), .dl_up_i(dl_up), .slot_o(slot));
    slot_hw hw (.clk_i(clk), .evt_req_i(evt_req), .button_press_o(btn), .power_fault_o(flt),
        .latch_open_o(lat), .presence_o(pres), .cmd_done_o(cmd));
    // the directed run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
        @(posedge clk);
    endtask : rd_chk
    // sel high waits for the message pulse, low for the interrupt level
    task automatic wait_for(input logic sel, input logic lvl);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 12 && !hit; i++) begin
            @(negedge clk);
            hit = ((sel ? slot.send_power_limit : slot.hot_plug_irq) === lvl);
        end
        chk(32'(hit), 32'h1);
        @(posedge clk);
    endtask : wait_for
    // capability word with slot number zero and interlock present; hot-plug and the other low bits come from low
    function automatic logic [31:0] cap_word(input logic [1:0] s, input logic [6:0] low);
        return {13'h0, 1'b0, 1'b1, s, 8'hA5, low};
    endfunction : cap_word
    task automatic t_reset();
        chk(32'(slot), 32'h0);
        rd_chk(CAP, 32'h0);
        wr_reg(CTL, 32'h0000_FFFF);
        rd_chk(CTL, 32'h8);
        wr_reg(CTL, 32'h0);
        rd_chk(CTL, 32'h0);
        rd_chk(12'h0FC, 32'h0);
        wr_reg(CAP, 32'hFFFF_FFFF);
        rd_chk(CAP, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_cap();
        wr_reg(hp_slot_pkg::OFF_PORT_CFG, 32'h1);
        @(posedge clk);
        wr_reg(CAP, 32'hFFFF_FFFF);
        wait_for(1'b1, 1'b1);
        chk(32'(slot.power_limit_msg), 32'h3FF);
        rd_chk(CAP, 32'hFFFB_FFDF);
        for (int s = 0; s < 4; s++) begin
            wr_reg(CAP, cap_word(2'(s), 7'h5F));
            wait_for(1'b1, 1'b1);
            chk(32'(slot.power_limit_msg), {22'h0, 2'(s), 8'hA5});
            rd_chk(CAP, cap_word(2'(s), 7'h5F));
        end
        $display("test capability done");
    endtask : t_cap
    task automatic t_ctl();
        rd_chk(CTL, 32'h1C0);
        chk(32'(slot.attention_ind), 32'h3);
        chk(32'(slot.power_ind), 32'h1);
        wr_reg(CTL, 32'hFFFF_FE7F);
        rd_chk(CTL, 32'h67F);
        chk({30'h0, slot.attention_ind}, 32'h1);
        chk({30'h0, slot.power_ind}, 32'h2);
        chk(32'(slot.power_off), 32'h1);
        wr_reg(CAP, cap_word(2'h3, 7'h57));
        rd_chk(CTL, 32'h63F);
        chk(32'(slot.attention_ind), 32'h0);
        wr_reg(CAP, cap_word(2'h3, 7'h5F));
        @(posedge clk);
        $display("test control done");
    endtask : t_ctl
    task automatic t_evt();
        wr_reg(CTL, 32'h1FF);
        for (int k = 0; k < 5; k++) begin
            evt_req <= 5'h01 << k;
            @(posedge clk);
            evt_req <= 5'h00;
            wait_for(1'b0, 1'b1);
            rd_chk(STS, 32'h1 << k);
            wr_reg(STS, 32'h1 << k);
            wait_for(1'b0, 1'b0);
        end
        $display("test events done");
    endtask : t_evt
    task automatic t_gate();
        wr_reg(CTL, 32'h1FE);
        evt_req <= 5'h01;
        @(posedge clk);
        evt_req <= 5'h00;
        repeat (10) begin
            @(negedge clk);
            chk(32'(slot.hot_plug_irq), 32'h0);
        end
        @(posedge clk);
        wr_reg(CTL, 32'h1DF);
        repeat (4) @(negedge clk);
        chk(32'(slot.hot_plug_irq), 32'h0);
        chk(32'(slot.wake), 32'h1);
        @(posedge clk);
        wr_reg(CTL, 32'h1FF);
        wait_for(1'b0, 1'b1);
        wr_reg(STS, 32'h1);
        wait_for(1'b0, 1'b0);
        $display("test gating done");
    endtask : t_gate
    task automatic t_link();
        dl_up <= 1'b1;
        wait_for(1'b1, 1'b1);
        chk(32'(slot.power_limit_msg), 32'h3A5);
        dl_up <= 1'b0;
        wr_reg(hp_slot_pkg::OFF_PORT_CFG, 32'h3);
        @(posedge clk);
        wr_reg(CTL, 32'h2C0);
        repeat (3) @(posedge clk);
        chk(32'(slot.power_ind), 32'h1);
        $display("test link and upstream done");
    endtask : t_link
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_cap();
        t_ctl();
        t_evt();
        t_gate();
        t_link();
        conclude();
    end
endmodule : tb_hp_slot_regs
`default_nettype wire
